/* File: rtl/pcsc_defines.vh */
// Constants for the clock and system control block
// Assumes 16-bit word addressing of the control window
`ifndef PCSC_DEFINES_VH
`define PCSC_DEFINES_VH

// ----------------------------------------
// Register word addresses
// ----------------------------------------
`define PCSC_HS_PRESCALER_ADDR 16'h701A
`define PCSC_LS_PRESCALER_ADDR 16'h701B
`define PCSC_CLK_ENABLES_ADDR 16'h701C
`define PCSC_LPM_CTRL0_ADDR 16'h701E
`define PCSC_LPM_CTRL1_ADDR 16'h701F
`define PCSC_PLL_RATIO_ADDR 16'h7021
`define PCSC_STATUS_ADDR 16'h7022
`define PCSC_WD_COUNT_ADDR 16'h7023
`define PCSC_WD_KEY_ADDR 16'h7025
`define PCSC_WD_CTRL_ADDR 16'h7029

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PCSC_RATIO_MSB 3
`define PCSC_RATIO_RESET 4'h0
`define PCSC_RATIO_MAX 4'hA
`define PCSC_REG_RESET 16'h0000
`define PCSC_WD_DIS_BIT 6
`define PCSC_ST_LIMP_BIT 0
`define PCSC_ST_LOST_BIT 1
`define PCSC_ST_PLLEN_BIT 2
`define PCSC_ST_OFF_BIT 3
`define PCSC_WD_KEY1 8'h55
`define PCSC_WD_KEY2 8'hAA
`define PCSC_WD_MAX 8'hFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define PCSC_SYS_CLK_KHZ 50000
`define PCSC_LIMP_KHZ 2000
`define PCSC_LIMP_HALF (`PCSC_SYS_CLK_KHZ / (2 * `PCSC_LIMP_KHZ))
`define PCSC_LOSS_CYCLES 64
`define PCSC_PLL_SETTLE_REF_CYCLES 131072

`endif

/* File: rtl/pcsc_top.v */
// Clock generation and protected system control registers
// Assumes reference clock sampled by sys_clk, word-wide register port
//
// Behaviour
// RQ1: Register writes need protected-write unlock active
// RQ2: Only external reset clears PLL ratio
// RQ3: Ratio field bits 3:0, upper bits zero
// RQ4: Ratio 0/1 halves input, else n/2
// RQ5: Strap low disables PLL, core equals input
// RQ6: Power-up starts in bypass divide-by-two
// RQ7: Nonzero ratio enables PLL, output halved; code enables PLL only for ratio 2 and above, ratio 1 stays in bypass
// RQ8: Input loss falls back to limp clock
// RQ9: Limp needs earlier nonzero ratio write
// RQ10: Watchdog advances while input clock present
// RQ11: Watchdog frozen while running on limp
// RQ12: Firmware disables watchdog around ratio change
// RQ13: Key 0x55 then 0xAA restarts watchdog
// RQ14: Strap sampled only during reset
// RQ15: Source switching is glitch free
`timescale 1ns/1ps
`include "pcsc_defines.vh"

module pcsc_top #(
   parameter RATIO_W = 4,
   parameter LOSS_W = 8,
   parameter LIMP_W = 8
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst_n,
   input wire emu_reset,
   // Clock pins
   input wire reference_clock_in,
   input wire pll_off_strap,
   // Register port
   input wire protected_write_unlock,
   input wire [15:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata,
   // Clock and watchdog outputs
   output reg core_clock_out,
   output reg watchdog_wake_interrupt,
   output reg limp_active
);

   // ----------------------------------------
   // Source states, one-hot
   // ----------------------------------------
   localparam [3:0] SRC_OFF = 4'b0001;
   localparam [3:0] SRC_BYP = 4'b0010;
   localparam [3:0] SRC_PLL = 4'b0100;
   localparam [3:0] SRC_LIMP = 4'b1000;
   localparam integer LOSS_LIM_I = `PCSC_LOSS_CYCLES;
   localparam integer LIMP_HALF_I = `PCSC_LIMP_HALF;
   localparam [LOSS_W-1:0] LOSS_LIM = LOSS_LIM_I[LOSS_W-1:0];
   localparam [LIMP_W-1:0] LIMP_HALF = LIMP_HALF_I[LIMP_W-1:0];

   reg rst_q1;
   reg rst_q2;
   reg strap_off;
   reg ref_q;
   reg ref_edge;
   reg [LOSS_W-1:0] loss_cnt;
   reg clk_lost;
   reg [LOSS_W-1:0] ref_period;
   reg [LOSS_W-1:0] period_cnt;
   reg [LOSS_W-1:0] acc;
   reg [LIMP_W-1:0] limp_cnt;
   reg [3:0] src;
   reg [3:0] next_src;
   reg [RATIO_W-1:0] ratio;
   reg ratio_written;
   reg [15:0] hs_prescaler;
   reg [15:0] ls_prescaler;
   reg [15:0] clk_enables;
   reg [15:0] lpm_ctrl0;
   reg [15:0] lpm_ctrl1;
   reg [15:0] wd_ctrl;
   reg [7:0] wd_key;
   reg [7:0] wd_count;
   reg wd_armed;
   reg toggle;
   reg [RATIO_W-1:0] mult;
   reg [LOSS_W:0] acc_sum;
   wire wr_ok;
   wire ref_rise;

   // Writes land only while unlocked
   assign wr_ok = reg_wr & protected_write_unlock; // see RQ1
   assign ref_rise = ref_q & ~ref_edge;

   // ----------------------------------------
   // Reset release and strap capture
   // ----------------------------------------

   // Two-stage reset release
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_q1 <= 1'b0;
         rst_q2 <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_q2 <= rst_q1;
      end
   end

   // Strap follows pin only while reset is held
   always @(posedge sys_clk) begin
      if (!rst_q2) begin
         strap_off <= ~pll_off_strap; // see RQ14
      end
   end

   // ----------------------------------------
   // Reference edge and loss detection
   // ----------------------------------------

   // Edge detect, period measure and loss timeout
   always @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         ref_q <= 1'b0;
         ref_edge <= 1'b0;
         loss_cnt <= {LOSS_W{1'b0}};
         clk_lost <= 1'b0;
         period_cnt <= {LOSS_W{1'b0}};
         ref_period <= {{(LOSS_W-1){1'b0}}, 1'b1};
      end else begin
         ref_q <= reference_clock_in;
         ref_edge <= ref_q;
         if (ref_rise) begin
            loss_cnt <= {LOSS_W{1'b0}};
            clk_lost <= 1'b0;
            period_cnt <= {{(LOSS_W-1){1'b0}}, 1'b1};
            if (period_cnt != {LOSS_W{1'b0}}) begin
               ref_period <= period_cnt;
            end
         end else begin
            if (period_cnt != LOSS_LIM) begin
               period_cnt <= period_cnt + 1'b1;
            end
            if (loss_cnt == LOSS_LIM) begin
               clk_lost <= 1'b1;
            end else begin
               loss_cnt <= loss_cnt + 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Source selection
   // ----------------------------------------

   // Wanted source from strap, ratio and loss
   always @* begin
      if (strap_off) begin
         next_src = SRC_OFF; // see RQ5
      end else if (ratio > {{(RATIO_W-1){1'b0}}, 1'b1}) begin
         if (clk_lost && ratio_written) begin
            next_src = SRC_LIMP; // see RQ8, RQ9
         end else begin
            next_src = SRC_PLL; // see RQ7
         end
      end else begin
         next_src = SRC_BYP; // see RQ4, RQ6
      end
      if (ratio > `PCSC_RATIO_MAX) begin
         mult = `PCSC_RATIO_MAX;
      end else begin
         mult = ratio;
      end
      acc_sum = {1'b0, acc} + {{(LOSS_W+1-RATIO_W){1'b0}}, mult};
   end

   // Toggle request for the active source
   always @* begin
      case (src)
         SRC_OFF: toggle = (ref_q != core_clock_out);
         SRC_BYP: toggle = ref_rise;
         // Lost input pulls a high output low so the limp switch can happen
         SRC_PLL: toggle = clk_lost ? core_clock_out : (acc_sum >= {1'b0, ref_period}); // see RQ15
         SRC_LIMP: toggle = (limp_cnt == LIMP_HALF);
         default: toggle = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Core clock generation
   // ----------------------------------------

   // Source changes only while the output is low
   always @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         src <= SRC_BYP;
         core_clock_out <= 1'b0;
         acc <= {LOSS_W{1'b0}};
         limp_cnt <= {LIMP_W{1'b0}};
         limp_active <= 1'b0;
      end else begin
         limp_active <= (src == SRC_LIMP);
         if (src == SRC_LIMP && limp_cnt != LIMP_HALF) begin
            limp_cnt <= limp_cnt + 1'b1;
         end else begin
            limp_cnt <= {LIMP_W{1'b0}};
         end
         // Multiplier accumulator: n steps per input period
         if (src == SRC_PLL && !clk_lost) begin
            if (toggle) begin
               acc <= acc_sum[LOSS_W-1:0] - ref_period;
            end else begin
               acc <= acc_sum[LOSS_W-1:0];
            end
         end else begin
            acc <= {LOSS_W{1'b0}};
         end
         if (next_src != src && !core_clock_out) begin
            src <= next_src; // see RQ15
         end else if (toggle) begin
            core_clock_out <= ~core_clock_out; // see RQ4, RQ7
         end
      end
   end

   // ----------------------------------------
   // Ratio register, external reset only
   // ----------------------------------------

   // Emulation reset leaves this alone
   always @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         ratio <= `PCSC_RATIO_RESET; // see RQ2
         ratio_written <= 1'b0;
      end else if (wr_ok && reg_addr == `PCSC_PLL_RATIO_ADDR) begin
         ratio <= reg_wdata[`PCSC_RATIO_MSB:0]; // see RQ3
         if (reg_wdata[`PCSC_RATIO_MSB:0] != 4'h0) begin
            ratio_written <= 1'b1; // see RQ9
         end
      end
   end

   // ----------------------------------------
   // Other protected registers
   // ----------------------------------------

   // Cleared by either reset
   always @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         hs_prescaler <= `PCSC_REG_RESET;
         ls_prescaler <= `PCSC_REG_RESET;
         clk_enables <= `PCSC_REG_RESET;
         lpm_ctrl0 <= `PCSC_REG_RESET;
         lpm_ctrl1 <= `PCSC_REG_RESET;
         wd_ctrl <= `PCSC_REG_RESET;
      end else if (emu_reset) begin
         hs_prescaler <= `PCSC_REG_RESET;
         ls_prescaler <= `PCSC_REG_RESET;
         clk_enables <= `PCSC_REG_RESET;
         lpm_ctrl0 <= `PCSC_REG_RESET;
         lpm_ctrl1 <= `PCSC_REG_RESET;
         wd_ctrl <= `PCSC_REG_RESET;
      end else if (wr_ok) begin
         case (reg_addr)
            `PCSC_HS_PRESCALER_ADDR: hs_prescaler <= reg_wdata; // see RQ1
            `PCSC_LS_PRESCALER_ADDR: ls_prescaler <= reg_wdata;
            `PCSC_CLK_ENABLES_ADDR: clk_enables <= reg_wdata;
            `PCSC_LPM_CTRL0_ADDR: lpm_ctrl0 <= reg_wdata;
            `PCSC_LPM_CTRL1_ADDR: lpm_ctrl1 <= reg_wdata;
            `PCSC_WD_CTRL_ADDR: wd_ctrl <= reg_wdata;
            default: wd_ctrl <= wd_ctrl;
         endcase
      end
   end

   // ----------------------------------------
   // Watchdog counter
   // ----------------------------------------

   // Counts input rising edges; frozen with no input
   always @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         wd_count <= 8'h00;
         wd_key <= 8'h00;
         wd_armed <= 1'b0;
         watchdog_wake_interrupt <= 1'b0;
      end else if (emu_reset) begin
         wd_count <= 8'h00;
         wd_key <= 8'h00;
         wd_armed <= 1'b0;
         watchdog_wake_interrupt <= 1'b0;
      end else begin
         watchdog_wake_interrupt <= 1'b0;
         if (wr_ok && reg_addr == `PCSC_WD_KEY_ADDR) begin
            wd_key <= reg_wdata[7:0];
            if (reg_wdata[7:0] == `PCSC_WD_KEY1) begin
               wd_armed <= 1'b1;
            end else if (reg_wdata[7:0] == `PCSC_WD_KEY2 && wd_armed) begin
               wd_armed <= 1'b0;
               wd_count <= 8'h00; // see RQ13
            end else begin
               wd_armed <= 1'b0;
            end
         end else if (!wd_ctrl[`PCSC_WD_DIS_BIT] && ref_rise && src != SRC_LIMP) begin
            // see RQ10, RQ11
            if (wd_count == `PCSC_WD_MAX) begin
               wd_count <= 8'h00;
               watchdog_wake_interrupt <= 1'b1;
            end else begin
               wd_count <= wd_count + 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Register read port
   // ----------------------------------------

   // Registered read data, unmapped reads zero
   always @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `PCSC_HS_PRESCALER_ADDR: reg_rdata <= hs_prescaler;
            `PCSC_LS_PRESCALER_ADDR: reg_rdata <= ls_prescaler;
            `PCSC_CLK_ENABLES_ADDR: reg_rdata <= clk_enables;
            `PCSC_LPM_CTRL0_ADDR: reg_rdata <= lpm_ctrl0;
            `PCSC_LPM_CTRL1_ADDR: reg_rdata <= lpm_ctrl1;
            `PCSC_PLL_RATIO_ADDR: reg_rdata <= {12'h000, ratio}; // see RQ3
            `PCSC_STATUS_ADDR: reg_rdata <= {12'h000, strap_off, (src == SRC_PLL),
                                             clk_lost, (src == SRC_LIMP)};
            `PCSC_WD_COUNT_ADDR: reg_rdata <= {8'h00, wd_count};
            `PCSC_WD_KEY_ADDR: reg_rdata <= {8'h00, wd_key};
            `PCSC_WD_CTRL_ADDR: reg_rdata <= wd_ctrl;
            default: reg_rdata <= 16'h0000;
         endcase
      end
   end

endmodule

/* File: tb/pcsc_ref_osc.sv */
// Reference oscillator model for the clock pin
// Assumes the bench sets run and the half period in sys_clk cycles
`timescale 1ns/1ps
module pcsc_ref_osc (
   // Clock
   input wire logic sys_clk,
   // Control
   input wire logic run,
   input wire logic [7:0] half,
   // Oscillator pin
   output logic ref_out
);
   logic [7:0] cnt = 8'h00;
   logic level = 1'b0;
   assign ref_out = level;
   // Toggle each half period; a dead oscillator stands still
   always @(negedge sys_clk) begin
      if (run && cnt + 8'h01 >= half) begin
         level <= ~level;
         cnt <= 8'h00;
      end else if (run) begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule

/* File: tb/pcsc_top_monitor.sv */
// Port checker for the clock and control block
// Assumes bind onto pcsc_top and a reference far slower than sys_clk
`timescale 1ns/1ps
`include "pcsc_defines.vh"
module pcsc_top_monitor #(
   parameter RATIO_W = 4,
   parameter LOSS_W = 8,
   parameter LIMP_W = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic emu_reset,
   // Pins
   input wire logic reference_clock_in,
   input wire logic pll_off_strap,
   // Register port
   input wire logic protected_write_unlock,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   // Outputs
   input wire logic core_clock_out,
   input wire logic watchdog_wake_interrupt,
   input wire logic limp_active
);
   logic [3:0] shadow;
   logic ever;
   logic strap_hi;
   logic [5:0] settle;
   logic [7:0] still;
   logic ref_q;
   wire wr_pll = reg_wr && protected_write_unlock && reg_addr == `PCSC_PLL_RATIO_ADDR;
   wire rd_pll = reg_rd && reg_addr == `PCSC_PLL_RATIO_ADDR;
   // Strap level captured only while reset is held
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         strap_hi <= pll_off_strap;
      end
   end
   // Ratio shadow and quiet-time counters
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         shadow <= 4'h0;
         ever <= 1'b0;
         settle <= 6'h00;
         still <= 8'h00;
         ref_q <= 1'b0;
      end else begin
         ref_q <= reference_clock_in;
         still <= (ref_q != reference_clock_in) ? 8'h00 : still + {7'h00, still != 8'hFF};
         settle <= wr_pll ? 6'h00 : settle + {5'h00, settle != 6'h3F};
         if (wr_pll) begin
            shadow <= reg_wdata[3:0];
            ever <= ever | (reg_wdata[3:0] != 4'h0);
         end
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_ratio_read_back: assert property (rd_pll |=> reg_rdata == {12'h000, $past(shadow)})
      else $error("ratio read back wrong");
   a_bypass_half: assert property (strap_hi && settle == 6'h3F && shadow < 4'h2 && !limp_active
      && $rose(reference_clock_in) |-> ##[2:3] $changed(core_clock_out)) else $error("bypass core missed");
   a_direct_follow: assert property (!strap_hi && settle == 6'h3F && $changed(reference_clock_in)
      |-> ##[1:4] core_clock_out == reference_clock_in) else $error("direct core not following");
   a_limp_on_loss: assert property (still == 8'd80 && ever && strap_hi && shadow > 4'h1 |-> ##[0:200] limp_active)
      else $error("no limp after loss");
   a_limp_rate: assert property (limp_active && $changed(core_clock_out) |=> $stable(core_clock_out)[*8])
      else $error("limp clock too fast");
   a_limp_needs_ratio: assert property (limp_active |-> ever)
      else $error("limp without ratio write");
   a_wd_frozen: assert property (limp_active |-> !watchdog_wake_interrupt)
      else $error("watchdog moved in limp");
   a_wake_pulse: assert property (watchdog_wake_interrupt |=> !watchdog_wake_interrupt[*8])
      else $error("wake pulse too long");
   c_limp: cover property ($rose(limp_active));
   c_wake: cover property (watchdog_wake_interrupt);
   c_ratio: cover property (rd_pll && ever);
endmodule
bind pcsc_top pcsc_top_monitor #(.RATIO_W(RATIO_W), .LOSS_W(LOSS_W), .LIMP_W(LIMP_W)) u_pcsc_top_monitor (
   .sys_clk(sys_clk), .rst_n(rst_n), .emu_reset(emu_reset), .reference_clock_in(reference_clock_in),
   .pll_off_strap(pll_off_strap), .protected_write_unlock(protected_write_unlock), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .core_clock_out(core_clock_out), .watchdog_wake_interrupt(watchdog_wake_interrupt), .limp_active(limp_active));

/* File: tb/test_pcsc_top.sv */
// Self-checking bench for the clock and control block
// Assumes the oscillator model and the checker bound beside the design
`timescale 1ns/1ps
`include "pcsc_defines.vh"
module test_pcsc_top;
   localparam logic [15:0] PLL = `PCSC_PLL_RATIO_ADDR;
   localparam logic [15:0] CNT = `PCSC_WD_COUNT_ADDR;
   localparam logic [15:0] KEY = `PCSC_WD_KEY_ADDR;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic emu_reset = 1'b0;
   logic strap = 1'b1;
   logic unlock = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata, v, w;
   logic ref_clk, core, wake, limp;
   logic osc_run = 1'b1;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   int n;
   // Rows: ratio and core rising edges over eight reference periods
   logic [3:0] row_ratio [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hA};
   logic [15:0] row_rises [6] = '{16'h0004, 16'h0004, 16'h0008, 16'h000C, 16'h0010, 16'h0028};
   pcsc_top u_pcsc_top (.sys_clk(sys_clk), .rst_n(rst_n), .emu_reset(emu_reset), .reference_clock_in(ref_clk),
      .pll_off_strap(strap), .protected_write_unlock(unlock), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .core_clock_out(core),
      .watchdog_wake_interrupt(wake), .limp_active(limp));
   pcsc_ref_osc u_pcsc_ref_osc (.sys_clk(sys_clk), .run(osc_run), .half(8'h14), .ref_out(ref_clk));
   always #10 sys_clk = ~sys_clk;
   // Cut a hang short
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Accept a measured count one off the ideal
   function automatic logic [15:0] near(input int got, input logic [15:0] exp);
      near = (got + 1 >= exp && got <= exp + 1) ? exp : 16'(got);
   endfunction
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   task automatic rises(input int cycles);
      logic prev;
      prev = core;
      n = 0;
      repeat (cycles) begin
         @(negedge sys_clk);
         if (core && !prev) n++;
         prev = core;
      end
   endtask
   task automatic do_reset(input logic s);
      osc_run = 1'b1;
      strap = s;
      rst_n = 1'b0;
      repeat (20) @(negedge sys_clk);
      check({13'h0, core, wake, limp}, 16'h0000);
      rst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      do_reset(1'b1);
      for (int i = 0; i < 6; i++) begin
         wr(PLL, {12'hFFF, row_ratio[i]});
         rd(PLL, v);
         check(v, {12'h000, row_ratio[i]});
         repeat (80) @(negedge sys_clk);
         rises(320);
         check(near(n, row_rises[i]), row_rises[i]);
      end
      $display("ratio table done");
      unlock = 1'b0;
      wr(PLL, 16'h0005);
      unlock = 1'b1;
      rd(PLL, v);
      check(v, 16'h000A);
      @(negedge sys_clk);
      emu_reset = 1'b1;
      @(negedge sys_clk);
      emu_reset = 1'b0;
      rd(PLL, v);
      check(v, 16'h000A);
      $display("lock and debug reset done");
      osc_run = 1'b0;
      repeat (400) if (!limp) @(negedge sys_clk);
      check({15'h0, limp}, 16'h0001);
      rises(260);
      check({15'h0, n >= 5 && n <= 21}, 16'h0001);
      rd(CNT, v);
      repeat (200) @(negedge sys_clk);
      rd(CNT, w);
      check(w, v);
      do_reset(1'b1);
      rd(PLL, v);
      check(v, 16'h0000);
      osc_run = 1'b0;
      repeat (300) @(negedge sys_clk);
      check({15'h0, limp}, 16'h0000);
      $display("limp tests done");
      do_reset(1'b1);
      rd(CNT, v);
      repeat (400) @(negedge sys_clk);
      rd(CNT, w);
      check(near(w - v, 16'h000A), 16'h000A);
      wr(KEY, 16'h0055);
      wr(KEY, 16'h00AA);
      rd(CNT, v);
      check({15'h0, v <= 16'h0001}, 16'h0001);
      repeat (12000) if (!wake) @(negedge sys_clk);
      check({15'h0, wake}, 16'h0001);
      wr(`PCSC_WD_CTRL_ADDR, 16'h0040);
      wr(PLL, 16'h0002);
      rd(CNT, v);
      repeat (200) @(negedge sys_clk);
      rd(CNT, w);
      check(w, v);
      $display("watchdog done");
      do_reset(1'b0);
      repeat (80) @(negedge sys_clk);
      rises(320);
      check(near(n, 16'h0008), 16'h0008);
      strap = 1'b1;
      rises(320);
      check(near(n, 16'h0008), 16'h0008);
      $display("strap done");
      finish_test();
   end
endmodule
